// File: common/cycle_timing_pkg.sv
// Shared constants and types for the instruction cycle accounting block
package cycle_timing_pkg;

	localparam int FETCH_WIDTH = 2;
	localparam int WORDS_WIDTH = 5;
	localparam int INTERNAL_WIDTH = 5;
	localparam int FETCH_BRANCH = 3;
	localparam int FETCH_NORMAL = 1;
	localparam int MOVE_INTERNAL = 3;
	localparam int MUL_MAX_INTERNAL = 16;
	localparam int COPRO_INTERNAL_ID = 15;
	localparam int COPRO_REG_LAST = 7;
	localparam int FLAGS_MSB = 31;
	localparam int FLAGS_LSB = 28;
	localparam logic [31:0] MUL_SAT_LIMIT = 32'h20000000;

	typedef enum logic [3:0] {
		CLASS_DATA_PROC,
		CLASS_WORD_LOAD,
		CLASS_WORD_STORE,
		CLASS_BLOCK_LOAD,
		CLASS_BLOCK_STORE,
		CLASS_ATOMIC_SWAP,
		CLASS_BRANCH,
		CLASS_SOFTWARE_INTERRUPT,
		CLASS_MULTIPLY,
		CLASS_COPRO_DATA_OP,
		CLASS_COPRO_LOAD,
		CLASS_COPRO_STORE,
		CLASS_COPRO_MOVE,
		CLASS_UNDEFINED,
		CLASS_EXCEPTION
	} instr_class_e;

	typedef enum logic [2:0] {
		PHASE_IDLE,
		PHASE_FETCH,
		PHASE_READ,
		PHASE_WRITE,
		PHASE_INTERNAL
	} phase_e;

endpackage

// File: common/cycle_plan_if.sv
// Cycle plan handed from the decoder to the sequencer
`timescale 1ns/1ps
`default_nettype none
interface cycle_plan_if;
	import cycle_timing_pkg::*;
	logic load;
	logic [1:0] fetches;
	logic [4:0] reads;
	logic [4:0] writes;
	logic [4:0] internals;
	logic trap;
	logic busy;

	modport decoder (output load, fetches, reads, writes, internals, trap, input busy);
	modport sequencer (input load, fetches, reads, writes, internals, trap, output busy);
endinterface
`default_nettype wire

// File: rtl/cycle_sequencer.sv
// Steps an instruction through its fetch, read, write and internal cycles
`timescale 1ns/1ps
`default_nettype none
module cycle_sequencer
	import cycle_timing_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	cycle_plan_if.sequencer plan,
	input wire logic cache_hit,
	input wire logic write_buffer_enable,
	input wire logic write_buffer_space,
	input wire logic mem_done,
	output phase_e phase,
	output logic cycle_step,
	output logic done_pulse
);

	logic [1:0] fetch_reg;
	logic [4:0] read_reg;
	logic [4:0] write_reg;
	logic [4:0] internal_reg;
	logic trap_reg;
	logic access_ok;

	// Hit or buffered write with space finishes in one cycle; a full buffer waits for space, misses and unbuffered writes wait for memory
	always_comb begin
		unique case (phase)
			PHASE_FETCH, PHASE_READ: access_ok = cache_hit || mem_done;
			PHASE_WRITE: access_ok = write_buffer_enable ? write_buffer_space : mem_done;
			PHASE_INTERNAL: access_ok = 1'b1;
			default: access_ok = 1'b0;
		endcase
	end

	assign cycle_step = access_ok && (phase != PHASE_IDLE);
	assign plan.busy = (phase != PHASE_IDLE);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			phase <= PHASE_IDLE;
			fetch_reg <= '0;
			read_reg <= '0;
			write_reg <= '0;
			internal_reg <= '0;
			trap_reg <= 1'b0;
			done_pulse <= 1'b0;
		end else begin
			done_pulse <= 1'b0;
			if (phase == PHASE_IDLE) begin
				if (plan.load) begin
					fetch_reg <= plan.fetches - 2'h1;
					read_reg <= plan.reads;
					write_reg <= plan.writes;
					internal_reg <= plan.internals;
					trap_reg <= plan.trap;
					phase <= PHASE_FETCH;
				end
			end else if (access_ok) begin
				// Read before write keeps the swap order
				if (phase == PHASE_FETCH && fetch_reg != 2'h0) begin
					fetch_reg <= fetch_reg - 2'h1;
				end else if (phase != PHASE_WRITE && phase != PHASE_INTERNAL && read_reg != 5'h0) begin
					read_reg <= read_reg - 5'h1;
					phase <= PHASE_READ;
				end else if (phase != PHASE_INTERNAL && write_reg != 5'h0) begin
					write_reg <= write_reg - 5'h1;
					phase <= PHASE_WRITE;
				end else if (internal_reg != 5'h0) begin
					internal_reg <= internal_reg - 5'h1;
					phase <= PHASE_INTERNAL;
				end else begin
					phase <= PHASE_IDLE;
					done_pulse <= 1'b1;
				end
			end
		end
	end

endmodule
`default_nettype wire

// File: rtl/instruction_cycle_timing.sv
// Cycle accounting and trap dispatch for one instruction at a time
// Notes on behaviour
// - Undefined instruction traps only when condition true
// - Failed condition costs one fetch only
// - Data processing: one fetch, shift adds internal
// - PC-writing data processing: three fetches
// - Word load: fetch, read, internal
// - Word load to PC: three fetches
// - Word store: fetch then one write
// - Block load: fetch, n reads, internal
// - Block load with PC: three fetches
// - Block store: fetch then n writes
// - Swap: fetch, read, write, internal
// - Multiply: one plus operand-dependent internals
// - Coprocessor ops trap except internal moves
// - Internal coprocessor move: fetch plus three internals
// - Internal cycle lasts one core clock
// - Fetch/read one cycle on hit
// - Buffered write one cycle with buffer space
// - Line fill or table walk lengthens
// - Move to PC updates only flags
`timescale 1ns/1ps
`default_nettype none
module instruction_cycle_timing
	import cycle_timing_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic issue_valid,
	input wire instr_class_e issue_class,
	input wire logic condition_pass,
	input wire logic shift_by_register,
	input wire logic writes_pc,
	input wire logic [4:0] word_count,
	input wire logic [31:0] multiplier_operand,
	input wire logic [3:0] copro_number,
	input wire logic [3:0] copro_register,
	input wire logic copro_to_core,
	input wire logic [31:0] copro_move_data,
	input wire logic copro_absent_a,
	input wire logic copro_absent_b,
	input wire logic cache_hit,
	input wire logic write_buffer_enable,
	input wire logic write_buffer_space,
	input wire logic mem_done,
	output logic issue_ready,
	output logic fetch_cycle,
	output logic read_cycle,
	output logic write_cycle,
	output logic internal_cycle,
	output logic trap_take,
	output logic refused_by_copro,
	output logic flags_write,
	output logic [3:0] flags_value,
	output logic instr_done
);

	cycle_plan_if plan ();
	phase_e phase;
	logic cycle_step;
	logic done_pulse;
	logic [1:0] fetches_next;
	logic [4:0] reads_next;
	logic [4:0] writes_next;
	logic [4:0] internals_next;
	logic trap_next;
	logic [4:0] mul_cycles;
	logic internal_move;
	logic trap_pending_reg;
	logic flags_pending_reg;
	logic [3:0] flags_hold_reg;

	// ----------------------------------------
	// Multiply length
	// ----------------------------------------
	// Two operand bits retired per internal cycle
	always_comb begin
		mul_cycles = 5'h1;
		if (multiplier_operand >= MUL_SAT_LIMIT) begin
			mul_cycles = 5'(MUL_MAX_INTERNAL);
		end else begin
			for (int m = 2; m < MUL_MAX_INTERNAL; m++) begin
				if (multiplier_operand >= (32'h1 << (2 * m - 3))) begin
					mul_cycles = 5'(m);
				end
			end
		end
	end

	assign internal_move = (copro_number == 4'(COPRO_INTERNAL_ID))
		&& (copro_register <= 4'(COPRO_REG_LAST));

	// ----------------------------------------
	// Cycle plan per class
	// ----------------------------------------
	always_comb begin
		fetches_next = 2'(FETCH_NORMAL);
		reads_next = 5'h0;
		writes_next = 5'h0;
		internals_next = 5'h0;
		trap_next = 1'b0;
		if (condition_pass) begin
			unique case (issue_class)
				CLASS_DATA_PROC: begin
					fetches_next = writes_pc ? 2'(FETCH_BRANCH) : 2'(FETCH_NORMAL);
					internals_next = shift_by_register ? 5'h1 : 5'h0;
				end
				CLASS_WORD_LOAD: begin
					fetches_next = writes_pc ? 2'(FETCH_BRANCH) : 2'(FETCH_NORMAL);
					reads_next = 5'h1;
					internals_next = 5'h1;
				end
				CLASS_WORD_STORE: writes_next = 5'h1;
				CLASS_BLOCK_LOAD: begin
					fetches_next = writes_pc ? 2'(FETCH_BRANCH) : 2'(FETCH_NORMAL);
					reads_next = word_count;
					internals_next = 5'h1;
				end
				CLASS_BLOCK_STORE: writes_next = word_count;
				CLASS_ATOMIC_SWAP: begin
					reads_next = 5'h1;
					writes_next = 5'h1;
					internals_next = 5'h1;
				end
				CLASS_BRANCH, CLASS_SOFTWARE_INTERRUPT, CLASS_EXCEPTION:
					fetches_next = 2'(FETCH_BRANCH);
				CLASS_MULTIPLY: internals_next = mul_cycles;
				CLASS_COPRO_MOVE: begin
					if (internal_move) begin
						internals_next = 5'(MOVE_INTERNAL);
					end else begin
						fetches_next = 2'(FETCH_BRANCH);
						trap_next = 1'b1;
					end
				end
				CLASS_COPRO_DATA_OP, CLASS_COPRO_LOAD, CLASS_COPRO_STORE, CLASS_UNDEFINED: begin
					fetches_next = 2'(FETCH_BRANCH);
					trap_next = 1'b1;
				end
				default: trap_next = 1'b1;
			endcase
		end
	end
	// A failed condition falls through with one fetch and nothing else

	assign plan.load = issue_valid && !plan.busy;
	assign plan.fetches = fetches_next;
	assign plan.reads = reads_next;
	assign plan.writes = writes_next;
	assign plan.internals = internals_next;
	assign plan.trap = trap_next;

	cycle_sequencer sequencer_inst (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.plan(plan),
		.cache_hit(cache_hit),
		.write_buffer_enable(write_buffer_enable),
		.write_buffer_space(write_buffer_space),
		.mem_done(mem_done),
		.phase(phase),
		.cycle_step(cycle_step),
		.done_pulse(done_pulse)
	);

	// ----------------------------------------
	// Per-cycle strobes
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			fetch_cycle <= 1'b0;
			read_cycle <= 1'b0;
			write_cycle <= 1'b0;
			internal_cycle <= 1'b0;
		end else begin
			fetch_cycle <= cycle_step && (phase == PHASE_FETCH);
			read_cycle <= cycle_step && (phase == PHASE_READ);
			write_cycle <= cycle_step && (phase == PHASE_WRITE);
			internal_cycle <= cycle_step && (phase == PHASE_INTERNAL);
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			issue_ready <= 1'b0;
			instr_done <= 1'b0;
		end else begin
			issue_ready <= !plan.busy && !plan.load;
			instr_done <= done_pulse;
		end
	end

	// ----------------------------------------
	// Trap dispatch
	// ----------------------------------------
	// The trap is taken at completion regardless; refused_by_copro records whether both external coprocessors refused
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			trap_pending_reg <= 1'b0;
			trap_take <= 1'b0;
			refused_by_copro <= 1'b0;
		end else begin
			trap_take <= 1'b0;
			if (plan.load) begin
				trap_pending_reg <= trap_next;
			end else if (done_pulse) begin
				trap_pending_reg <= 1'b0;
			end
			if (done_pulse && trap_pending_reg) begin
				trap_take <= 1'b1;
				refused_by_copro <= copro_absent_a && copro_absent_b;
			end
		end
	end

	// ----------------------------------------
	// Flag update from coprocessor move
	// ----------------------------------------
	// Only the four flag bits travel; pc and other status stay as they were
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			flags_pending_reg <= 1'b0;
			flags_hold_reg <= 4'h0;
			flags_write <= 1'b0;
			flags_value <= 4'h0;
		end else begin
			flags_write <= 1'b0;
			// A take in the done cycle must not lose its own pending flag
			if (plan.load) begin
				flags_pending_reg <= condition_pass && (issue_class == CLASS_COPRO_MOVE)
					&& internal_move && copro_to_core && writes_pc;
				flags_hold_reg <= copro_move_data[FLAGS_MSB:FLAGS_LSB];
			end else if (done_pulse) begin
				flags_pending_reg <= 1'b0;
			end
			if (done_pulse && flags_pending_reg) begin
				flags_write <= 1'b1;
				flags_value <= flags_hold_reg;
			end
		end
	end

endmodule
`default_nettype wire

// File: sim/instruction_cycle_timing_checker.sv
// Port-level assertions for the cycle accounting block
`timescale 1ns/1ps
`default_nettype none
module instruction_cycle_timing_checker
	import cycle_timing_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic issue_valid,
	input wire instr_class_e issue_class,
	input wire logic condition_pass,
	input wire logic writes_pc,
	input wire logic [3:0] copro_number,
	input wire logic [3:0] copro_register,
	input wire logic copro_to_core,
	input wire logic [31:0] copro_move_data,
	input wire logic issue_ready,
	input wire logic fetch_cycle,
	input wire logic read_cycle,
	input wire logic write_cycle,
	input wire logic internal_cycle,
	input wire logic trap_take,
	input wire logic flags_write,
	input wire logic [3:0] flags_value
);
	instr_class_e cls_reg;
	logic cond_reg;
	logic flag_ok_reg;
	logic rd_seen_reg;
	logic [3:0] flag_reg;
	// Snapshot at take; strobes until the next take belong to it
	always_ff @(posedge sys_clk) begin
		if (issue_valid && issue_ready) begin
			cls_reg <= issue_class;
			cond_reg <= condition_pass;
			flag_reg <= copro_move_data[31:28];
			flag_ok_reg <= issue_class == CLASS_COPRO_MOVE && condition_pass && writes_pc
				&& copro_to_core && copro_number == 4'hf && copro_register <= 4'h7;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (issue_valid && issue_ready)
			rd_seen_reg <= 1'b0;
		else if (read_cycle)
			rd_seen_reg <= 1'b1;
	end
	// ------------------------------
	// Assertions
	// ------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	chk_one_strobe: assert property ($onehot0({fetch_cycle, read_cycle, write_cycle, internal_cycle}))
		else $error("strobes overlap");
	chk_fail_fetch_only: assert property (!cond_reg |-> !(read_cycle || write_cycle || internal_cycle))
		else $error("skipped instruction did work");
	chk_fail_no_trap: assert property (trap_take |-> cond_reg)
		else $error("trap on failed condition");
	chk_trap_class: assert property (trap_take |-> cls_reg inside {CLASS_UNDEFINED, CLASS_COPRO_DATA_OP,
		CLASS_COPRO_LOAD, CLASS_COPRO_STORE, CLASS_COPRO_MOVE})
		else $error("trap on wrong class");
	chk_store_internal: assert property (internal_cycle |-> !(cls_reg inside {CLASS_WORD_STORE, CLASS_BLOCK_STORE}))
		else $error("store with internal cycle");
	chk_read_class: assert property (read_cycle |-> cls_reg inside {CLASS_WORD_LOAD, CLASS_BLOCK_LOAD, CLASS_ATOMIC_SWAP})
		else $error("read on wrong class");
	chk_swap_order: assert property (write_cycle && cls_reg == CLASS_ATOMIC_SWAP |-> rd_seen_reg)
		else $error("swap write before read");
	chk_flags_value: assert property (flags_write |-> flag_ok_reg && flags_value == flag_reg)
		else $error("flags wrong");
endmodule
`default_nettype wire

// File: sim/copro_mem_model.sv
// Memory system and absent coprocessors beside the block
`timescale 1ns/1ps
`default_nettype none
module copro_mem_model (
	input wire logic sys_clk,
	input wire logic slow,
	output logic cache_hit,
	output logic write_buffer_space,
	output logic mem_done,
	output logic copro_absent_a,
	output logic copro_absent_b
);
	int seed = 37;
	logic [31:0] rv;
	// No coprocessor ever accepts an offered instruction
	assign copro_absent_a = 1'b1;
	assign copro_absent_b = 1'b1;
	initial begin
		cache_hit = 1'b1;
		write_buffer_space = 1'b1;
		mem_done = 1'b0;
		forever begin
			@(posedge sys_clk);
			rv = $random(seed);
			#1 cache_hit = !slow || rv[0];
			write_buffer_space = !slow || rv[1];
			// Fills and walks finish at random, not when asked; fast memory answers at once
			mem_done = !slow || rv[3:2] == 2'h0;
		end
	end
endmodule
`default_nettype wire

// File: sim/instruction_cycle_timing_bench.sv
// Self-checking bench for the cycle accounting block
`timescale 1ns/1ps
`default_nettype none
module instruction_cycle_timing_bench;
	import cycle_timing_pkg::*;
	logic sys_clk = 0;
	logic reset_n = 0;
	logic issue_valid = 0;
	instr_class_e issue_class = CLASS_DATA_PROC;
	logic condition_pass = 1;
	logic shift_by_register = 0;
	logic writes_pc = 0;
	logic [4:0] word_count = 0;
	logic [31:0] multiplier_operand = 0;
	logic [3:0] copro_number = 0;
	logic [3:0] copro_register = 0;
	logic copro_to_core = 0;
	logic [31:0] copro_move_data = 0;
	logic write_buffer_enable = 1;
	logic slow = 0;
	logic copro_absent_a, copro_absent_b, cache_hit, write_buffer_space, mem_done;
	logic issue_ready, fetch_cycle, read_cycle, write_cycle, internal_cycle, trap_take;
	logic refused_by_copro, flags_write, instr_done;
	logic [3:0] flags_value;
	logic [37:0] exp_q[$];
	logic [7:0] nf = 0, nr = 0, nw = 0, ni = 0;
	logic tk = 0, fw = 0;
	logic [3:0] fv = 0;
	logic [31:0] rv;
	logic [31:0] mul_tbl[8] = '{32'h0, 32'h1, 32'h2, 32'h7, 32'h8, 32'h1fffffff, 32'h20000000, 32'hffffffff};
	int failures = 0;
	int samples_checked = 0;
	int seed = 37;
	instruction_cycle_timing i_instruction_cycle_timing (.*);
	copro_mem_model i_copro_mem_model (.*);
	initial forever #50 sys_clk = ~sys_clk;
	function automatic logic [7:0] mul_cycles(input logic [31:0] x);
		mul_cycles = 8'h10;
		for (int m = 15; m >= 2; m--)
			if (x < (32'h1 << (2 * m - 1))) mul_cycles = 8'(m);
		if (x < 32'h2) mul_cycles = 8'h1;
	endfunction
	task print_verdict;
		if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ------------------------------
	// Driver: note expectation, issue, wait
	// ------------------------------
	task automatic run;
		logic [7:0] f, r, w, i;
		logic t, x;
		logic [3:0] v;
		int n;
		f = 8'h1; r = 8'h0; w = 8'h0; i = 8'h0; t = 0; x = 0; v = 4'h0;
		if (condition_pass) case (issue_class)
			CLASS_DATA_PROC: begin f = writes_pc ? 8'h3 : 8'h1; i = {7'h0, shift_by_register}; end
			CLASS_WORD_LOAD: begin f = writes_pc ? 8'h3 : 8'h1; r = 8'h1; i = 8'h1; end
			CLASS_WORD_STORE: w = 8'h1;
			CLASS_BLOCK_LOAD: begin f = writes_pc ? 8'h3 : 8'h1; r = {3'h0, word_count}; i = 8'h1; end
			CLASS_BLOCK_STORE: w = {3'h0, word_count};
			CLASS_ATOMIC_SWAP: begin r = 8'h1; w = 8'h1; i = 8'h1; end
			CLASS_MULTIPLY: i = mul_cycles(multiplier_operand);
			CLASS_COPRO_MOVE: if (copro_number == 4'hf && copro_register <= 4'h7) begin
				i = 8'h3;
				x = copro_to_core && writes_pc;
				v = x ? copro_move_data[31:28] : 4'h0;
			end else begin f = 8'h3; t = 1; end
			CLASS_BRANCH, CLASS_SOFTWARE_INTERRUPT, CLASS_EXCEPTION: f = 8'h3;
			default: begin f = 8'h3; t = 1; end
		endcase
		exp_q.push_back({t, x, v, f, r, w, i});
		issue_valid = 1;
		while (issue_ready !== 1'b1) @(negedge sys_clk);
		@(posedge sys_clk);
		#1 issue_valid = 0;
		n = 0;
		while (instr_done !== 1'b1 && n < 500) begin @(negedge sys_clk); n++; end
		if (n == 500) failures++;
	endtask
	// Monitor: counts strobes and compares at each completion
	always @(posedge sys_clk) if (reset_n) begin
		nf += {7'h0, fetch_cycle}; nr += {7'h0, read_cycle};
		nw += {7'h0, write_cycle}; ni += {7'h0, internal_cycle};
		tk |= trap_take;
		if (trap_take === 1'b1) begin
			samples_checked++;
			if (refused_by_copro !== 1'b1) begin
				failures++;
				$display("wrong value at %0t: got %h expected %h", $time, refused_by_copro, 1'b1);
			end
		end
		if (flags_write === 1'b1) begin fw = 1; fv = flags_value; end
		if (instr_done === 1'b1) begin
			samples_checked++;
			if ({tk, fw, fv, nf, nr, nw, ni} !== exp_q[0]) begin
				failures++;
				$display("wrong value at %0t: got %h expected %h", $time, {tk, fw, fv, nf, nr, nw, ni}, exp_q[0]);
			end
			void'(exp_q.pop_front());
			{tk, fw, fv, nf, nr, nw, ni} = 0;
		end
	end
	initial begin
		repeat (4) @(posedge sys_clk);
		#1 reset_n = 1;
		for (int k = 0; k < 80; k++) begin
			@(posedge sys_clk);
			rv = $random(seed);
			#1 issue_class = instr_class_e'(k % 15);
			condition_pass = k < 30 || rv[1:0] != 2'h0;
			shift_by_register = rv[2];
			writes_pc = rv[3];
			word_count = rv[8:4];
			multiplier_operand = 32'h1 << rv[13:9];
			copro_number = rv[14] ? 4'hf : rv[18:15];
			copro_register = rv[22:19];
			copro_to_core = rv[23];
			copro_move_data = $random(seed);
			write_buffer_enable = rv[28];
			slow = k >= 40;
			run;
		end
		for (int j = 0; j < 10; j++) begin
			@(posedge sys_clk);
			#1 condition_pass = 1;
			issue_class = j < 8 ? CLASS_MULTIPLY : CLASS_COPRO_MOVE;
			multiplier_operand = mul_tbl[j % 8];
			copro_number = 4'hf;
			copro_register = 4'(j - 1);
			copro_to_core = 1;
			writes_pc = 1;
			run;
		end
		print_verdict;
	end
	initial begin
		repeat (30000) @(posedge sys_clk);
		failures++;
		print_verdict;
	end
endmodule
bind instruction_cycle_timing instruction_cycle_timing_checker i_instruction_cycle_timing_checker (.*);
`default_nettype wire
